// file: include/ulm_pkg.sv
// Register map, field positions and carrier types of the line/modem status slice
package ulm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MLC = 8'h00;
  localparam logic [7:0] OFS_LST = 8'h04;
  localparam logic [7:0] OFS_MIS = 8'h08;
  localparam logic [7:0] OFS_SCR = 8'h0c;
  localparam logic [7:0] OFS_ENH = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;

  // Reset values
  localparam logic [7:0] SCR_RST = 8'hff;
  localparam logic [7:0] REG_RST = 8'h00;

  // modem_line_control fields
  localparam int MLC_DTR  = 0;
  localparam int MLC_RTS  = 1;
  localparam int MLC_RING = 2;
  localparam int MLC_AUX  = 3;
  localparam int MLC_LOOP = 4;
  localparam int MLC_XANY = 5;
  localparam int MLC_IR   = 6;
  localparam int MLC_PRE  = 7;

  // enhanced_feature_reg and irq_enable_reg fields
  localparam int ENH_EN   = 4;
  localparam int ENH_ACTS = 7;
  localparam int IRQ_LS   = 2;
  localparam int IRQ_MS   = 3;

  // extra_feature_enables fields
  localparam int EFE_TXD = 4;
  localparam int EFE_RXD = 5;
  localparam int EFE_9B  = 6;
  localparam int EFE_FIR = 7;

  // line_status fields
  localparam int LST_DR   = 0;
  localparam int LST_OE   = 1;
  localparam int LST_PE   = 2;
  localparam int LST_FE   = 3;
  localparam int LST_BI   = 4;
  localparam int LST_THRE = 5;
  localparam int LST_TEMT = 6;
  localparam int LST_ERR  = 7;

  // Infrared pulse widths in 16x sample ticks, and decoder stretch
  localparam logic [3:0] IR_SLOW_W  = 4'h3;
  localparam logic [3:0] IR_FAST_W  = 4'h4;
  localparam logic [3:0] IR_STRETCH = 4'hf;

  // Prescaler: divide by four ends on count three
  localparam logic [1:0] PRE_LAST = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_MLC  = 3'b001,
    SEL_LST  = 3'b010,
    SEL_MIS  = 3'b011,
    SEL_SCR  = 3'b100,
    SEL_ENH  = 3'b101,
    SEL_IRQ  = 3'b110
  } ulm_sel_t;

  // Active-low modem inputs as seen on the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic cd_n;
  } ulm_modem_t;

  // Character completion event from the receive shifter
  typedef struct packed {
    logic done;
    logic pe;
    logic fe;
    logic flow_char;
  } ulm_rx_evt_t;

  // Control levels to the transmit and receive engines
  typedef struct packed {
    logic tx_disable;
    logic rx_disable;
    logic nine_bit;
    logic fast_ir;
    logic loopback;
    logic xon_any;
    logic ir_enable;
    logic cts_hold;
  } ulm_ctrl_t;
endpackage

// file: rtl/ulm_status_ctrl.sv
// Line status, modem status and control slice of the UART with AXI4-Lite registers
`timescale 1ns/1ps

// Function
// - Loop bit routes transmit into own receiver
// - Xon-any resumes halted transmitter on any character
// - Infrared routing; infrared output low when idle
// - Prescale bit divides baud clock by four
// - Upper control bits writable only with enhancements
// - Overrun interrupts immediately, tags at head
// - Data ready while receive queue nonempty
// - Overrun on full queue, queue untouched
// - Parity and framing tags travel with character
// - Break loads one character, held until high
// - Holding empty follows transmit queue empty
// - Transmitter empty needs queue and shifter empty
// - Error summary while any tagged character queued
// - Modem input changes set deltas and interrupt
// - Ring delta only at end of ring
// - Upper modem status inverted or loopback mapped
// - Automatic CTS holds transmitter while high
// - Feature bits disable transmitter or receiver
// - Feature bit selects nine-bit multidrop mode
// - Feature bit selects fast infrared pulse width
// - Scratch register, reset to all ones
// - Loopback drives internal ring and aux two
module ulm_status_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DEPTH  = 64
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Receive engine
  input  wire ulm_pkg::ulm_rx_evt_t  rx_evt,
  input  wire logic                  rx_break_frame,
  input  wire logic                  rx_pop,
  output logic                       rx_store,
  output logic                       rx_to_receiver,
  // Transmit engine
  input  wire logic                  tx_fifo_empty,
  input  wire logic                  tx_shift_empty,
  input  wire logic                  tx_halted,
  input  wire logic                  tx_serial,
  input  wire logic [3:0]            tx_bit_phase,
  input  wire logic                  baud16_en,
  output logic                       tx_resume,
  output logic                       brg_clk_en,
  output ulm_pkg::ulm_ctrl_t         ctrl,
  // Line and modem pins
  input  wire logic                  rx_pin,
  input  wire logic                  ir_rx_pin,
  output logic                       tx_pin,
  input  wire ulm_pkg::ulm_modem_t   modem_pins,
  output logic                       dtr_n,
  output logic                       rts_n,
  output logic                       ri_loop_n,
  output logic                       aux_output_two_n,
  // Interrupt requests to the interrupt prioritiser
  output logic                       line_irq,
  output logic                       mdm_irq
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);

  typedef struct packed {
    logic                    awv;
    logic [ADDR_W-1:0]       awaddr;
    logic                    wv;
    logic [7:0]              wbyte;
    logic                    wlane;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    logic [7:0]              mlc;
    logic [7:0]              efc;
    logic [7:0]              irq_en;
    logic [3:0]              efe;
    logic [7:0]              scr;
    logic                    overrun;
    logic [3:0]              delta;
    logic [3:0]              mstat_prev;
    logic                    brk_hold;
    logic [1:0]              pre_cnt;
    logic                    pre_en;
    logic                    tx_out;
    logic                    rx_out;
    logic [3:0]              ir_cnt;
    logic                    store;
    logic                    resume;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [CW-1:0]           q_cnt;
    logic [CW-1:0]           err_cnt;
    logic [DEPTH-1:0][2:0]   tags;
  } ulm_state_t;

  ulm_state_t s_reg;
  ulm_state_t s_next;

  function automatic ulm_pkg::ulm_sel_t dec_addr(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(ulm_pkg::OFS_MLC))
      return ulm_pkg::SEL_MLC;
    else if (a == ADDR_W'(ulm_pkg::OFS_LST))
      return ulm_pkg::SEL_LST;
    else if (a == ADDR_W'(ulm_pkg::OFS_MIS))
      return ulm_pkg::SEL_MIS;
    else if (a == ADDR_W'(ulm_pkg::OFS_SCR))
      return ulm_pkg::SEL_SCR;
    else if (a == ADDR_W'(ulm_pkg::OFS_ENH))
      return ulm_pkg::SEL_ENH;
    else if (a == ADDR_W'(ulm_pkg::OFS_IRQ))
      return ulm_pkg::SEL_IRQ;
    else
      return ulm_pkg::SEL_NONE;
  endfunction

  logic        loop;
  logic        enh;
  logic [3:0]  mstat;
  logic [2:0]  head_tag;
  logic [7:0]  lst_val;
  logic [7:0]  mis_val;
  logic        q_full;

  always_comb
  begin
    loop     = s_reg.mlc[ulm_pkg::MLC_LOOP];
    enh      = s_reg.efc[ulm_pkg::ENH_EN];
    q_full   = (s_reg.q_cnt == FULL_CNT);
    head_tag = (s_reg.q_cnt != '0) ? s_reg.tags[s_reg.rd_ptr] : 3'h0;
    // Order is CD, RI, DSR, CTS in the active-high sense
    if (loop)
      mstat = {s_reg.mlc[ulm_pkg::MLC_AUX], s_reg.mlc[ulm_pkg::MLC_RING],
               s_reg.mlc[ulm_pkg::MLC_DTR], s_reg.mlc[ulm_pkg::MLC_RTS]};
    else
      mstat = ~{modem_pins.cd_n, modem_pins.ri_n, modem_pins.dsr_n, modem_pins.cts_n};
    lst_val = '0;
    lst_val[ulm_pkg::LST_DR]   = (s_reg.q_cnt != '0);
    lst_val[ulm_pkg::LST_OE]   = s_reg.overrun;
    lst_val[ulm_pkg::LST_PE]   = head_tag[2];
    lst_val[ulm_pkg::LST_FE]   = head_tag[1];
    lst_val[ulm_pkg::LST_BI]   = head_tag[0];
    lst_val[ulm_pkg::LST_THRE] = tx_fifo_empty;
    lst_val[ulm_pkg::LST_TEMT] = tx_fifo_empty & tx_shift_empty;
    lst_val[ulm_pkg::LST_ERR]  = (s_reg.err_cnt != '0);
    mis_val = {mstat, s_reg.delta};
  end

  always_comb
  begin
    logic             aw_hs;
    logic             w_hs;
    logic             ar_hs;
    logic             do_wr;
    logic             push;
    logic             pop;
    logic [2:0]       push_tag;
    logic [3:0]       chg;
    logic [3:0]       ir_w;
    ulm_pkg::ulm_sel_t wsel;
    ulm_pkg::ulm_sel_t rsel;
    aw_hs    = s_axi_awvalid & ~s_reg.awv & ~s_reg.bvalid;
    w_hs     = s_axi_wvalid & ~s_reg.wv & ~s_reg.bvalid;
    ar_hs    = s_axi_arvalid & ~s_reg.rvalid;
    do_wr    = s_reg.awv & s_reg.wv & ~s_reg.bvalid;
    wsel     = dec_addr(s_reg.awaddr);
    rsel     = dec_addr(s_axi_araddr);
    pop      = rx_pop & (s_reg.q_cnt != '0);
    ir_w     = s_reg.efe[ulm_pkg::EFE_FIR - 4] ? ulm_pkg::IR_FAST_W : ulm_pkg::IR_SLOW_W;
    push     = 1'b0;
    push_tag = 3'h0;
    chg      = '0;
    s_next   = s_reg;

    // Write channel: address and data taken in either order
    if (aw_hs)
    begin
      s_next.awv    = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      s_next.wv    = 1'b1;
      s_next.wbyte = s_axi_wdata[7:0];
      s_next.wlane = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      s_next.awv    = 1'b0;
      s_next.wv     = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = ulm_pkg::RESP_OKAY;
      if (wsel == ulm_pkg::SEL_NONE)
        s_next.bresp = ulm_pkg::RESP_SLVERR;
      else if (s_reg.wlane)
      begin
        case (wsel)
          ulm_pkg::SEL_MLC:
          begin
            s_next.mlc[4:0] = s_reg.wbyte[4:0];
            if (enh)
              s_next.mlc[7:5] = s_reg.wbyte[7:5];
          end
          ulm_pkg::SEL_MIS:
          begin
            if (enh)
              s_next.efe = s_reg.wbyte[7:4];
          end
          ulm_pkg::SEL_SCR: s_next.scr = s_reg.wbyte;
          ulm_pkg::SEL_ENH: s_next.efc = s_reg.wbyte;
          ulm_pkg::SEL_IRQ: s_next.irq_en = s_reg.wbyte;
          default:          s_next.bresp = ulm_pkg::RESP_OKAY;
        endcase
      end
    end
    if (s_reg.bvalid & s_axi_bready)
      s_next.bvalid = 1'b0;

    // Read channel; status reads clear their flags before new events set them
    if (s_reg.rvalid & s_axi_rready)
      s_next.rvalid = 1'b0;
    if (ar_hs)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = ulm_pkg::RESP_OKAY;
      s_next.rdata  = '0;
      if (rsel == ulm_pkg::SEL_MLC)
        s_next.rdata = s_reg.mlc;
      else if (rsel == ulm_pkg::SEL_LST)
      begin
        s_next.rdata   = lst_val;
        s_next.overrun = 1'b0;
      end
      else if (rsel == ulm_pkg::SEL_MIS)
      begin
        s_next.rdata = mis_val;
        s_next.delta = '0;
      end
      else if (rsel == ulm_pkg::SEL_SCR)
        s_next.rdata = s_reg.scr;
      else if (rsel == ulm_pkg::SEL_ENH)
        s_next.rdata = s_reg.efc;
      else if (rsel == ulm_pkg::SEL_IRQ)
        s_next.rdata = s_reg.irq_en;
      else
        s_next.rresp = ulm_pkg::RESP_SLVERR;
    end

    // Modem deltas, set wins over the read clear
    chg[0] = mstat[0] ^ s_reg.mstat_prev[0];
    chg[1] = mstat[1] ^ s_reg.mstat_prev[1];
    chg[2] = ~mstat[2] & s_reg.mstat_prev[2];
    chg[3] = mstat[3] ^ s_reg.mstat_prev[3];
    s_next.delta      = s_next.delta | chg;
    s_next.mstat_prev = mstat;

    // Receive queue bookkeeping; character data lives in the receive engine
    s_next.store  = 1'b0;
    s_next.resume = 1'b0;
    if (rx_evt.done & ~s_reg.efe[ulm_pkg::EFE_RXD - 4])
    begin
      if (s_reg.mlc[ulm_pkg::MLC_XANY] & tx_halted)
        s_next.resume = 1'b1;
      if (!rx_evt.flow_char)
      begin
        if (q_full)
          s_next.overrun = 1'b1;
        else
        begin
          push     = 1'b1;
          push_tag = {rx_evt.pe, rx_evt.fe, 1'b0};
        end
      end
    end
    // Only one break character per low period
    if (rx_break_frame & ~s_reg.brk_hold & ~s_reg.efe[ulm_pkg::EFE_RXD - 4])
    begin
      s_next.brk_hold = 1'b1;
      if (q_full)
        s_next.overrun = 1'b1;
      else
      begin
        push     = 1'b1;
        push_tag = 3'h1;
      end
    end
    if (s_reg.brk_hold & rx_to_receiver)
      s_next.brk_hold = 1'b0;
    if (push)
    begin
      s_next.tags[s_reg.wr_ptr] = push_tag;
      s_next.wr_ptr = s_reg.wr_ptr + PW'(1);
    end
    if (pop)
      s_next.rd_ptr = s_reg.rd_ptr + PW'(1);
    if (push & ~pop)
      s_next.q_cnt = s_reg.q_cnt + ONE_CNT;
    else if (pop & ~push)
      s_next.q_cnt = s_reg.q_cnt - ONE_CNT;
    s_next.err_cnt = s_reg.err_cnt + ((push && push_tag != 3'h0) ? ONE_CNT : '0)
                     - ((pop && head_tag != 3'h0) ? ONE_CNT : '0);
    s_next.store = push;

    // Baud clock prescaler: every cycle, or every fourth
    s_next.pre_cnt = s_reg.pre_cnt + 2'h1;
    if (s_reg.mlc[ulm_pkg::MLC_PRE])
      s_next.pre_en = (s_reg.pre_cnt == ulm_pkg::PRE_LAST);
    else
      s_next.pre_en = 1'b1;

    // Transmit pin: idle mark in loopback, pulses only on zero bits in infrared
    if (loop)
      s_next.tx_out = 1'b1;
    else if (s_reg.mlc[ulm_pkg::MLC_IR])
      s_next.tx_out = ~tx_serial & (tx_bit_phase < ir_w);
    else
      s_next.tx_out = tx_serial;

    // Infrared decoder stretches a pulse into a zero bit
    if (ir_rx_pin)
      s_next.ir_cnt = ulm_pkg::IR_STRETCH;
    else if (baud16_en && s_reg.ir_cnt != 4'h0)
      s_next.ir_cnt = s_reg.ir_cnt - 4'h1;
    if (loop)
      s_next.rx_out = tx_serial;
    else if (s_reg.mlc[ulm_pkg::MLC_IR])
      s_next.rx_out = ~ir_rx_pin & (s_reg.ir_cnt == 4'h0);
    else
      s_next.rx_out = rx_pin;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg        <= '0;
      s_reg.mlc    <= ulm_pkg::REG_RST;
      s_reg.efc    <= ulm_pkg::REG_RST;
      s_reg.irq_en <= ulm_pkg::REG_RST;
      s_reg.scr    <= ulm_pkg::SCR_RST;
      s_reg.tx_out <= 1'b1;
      s_reg.rx_out <= 1'b1;
      s_reg.pre_en <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // Bus handshake outputs are combinational from held state
  assign s_axi_awready = ~s_reg.awv & ~s_reg.bvalid;
  assign s_axi_wready  = ~s_reg.wv & ~s_reg.bvalid;
  assign s_axi_arready = ~s_reg.rvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rresp   = s_reg.rresp;
  assign s_axi_rdata   = {24'h000000, s_reg.rdata};

  assign rx_store       = s_reg.store;
  assign rx_to_receiver = s_reg.rx_out;
  assign tx_pin         = s_reg.tx_out;
  assign tx_resume      = s_reg.resume;
  assign brg_clk_en     = s_reg.pre_en;

  // DTR and RTS rest inactive in loopback; ring and aux two outputs are driven only in loopback
  assign dtr_n            = loop | ~s_reg.mlc[ulm_pkg::MLC_DTR];
  assign rts_n            = loop | ~s_reg.mlc[ulm_pkg::MLC_RTS];
  assign ri_loop_n        = ~(loop & s_reg.mlc[ulm_pkg::MLC_RING]);
  assign aux_output_two_n = ~(loop & s_reg.mlc[ulm_pkg::MLC_AUX]);

  // Tagged head raises the line interrupt only once it reaches the holding slot
  assign line_irq = s_reg.irq_en[ulm_pkg::IRQ_LS] & (s_reg.overrun | (head_tag != 3'h0));
  assign mdm_irq  = s_reg.irq_en[ulm_pkg::IRQ_MS] & (s_reg.delta != 4'h0);

  assign ctrl.tx_disable = s_reg.efe[ulm_pkg::EFE_TXD - 4];
  assign ctrl.rx_disable = s_reg.efe[ulm_pkg::EFE_RXD - 4];
  assign ctrl.nine_bit   = s_reg.efe[ulm_pkg::EFE_9B - 4];
  assign ctrl.fast_ir    = s_reg.efe[ulm_pkg::EFE_FIR - 4];
  assign ctrl.loopback   = loop;
  assign ctrl.xon_any    = s_reg.mlc[ulm_pkg::MLC_XANY];
  assign ctrl.ir_enable  = s_reg.mlc[ulm_pkg::MLC_IR];
  // Auto CTS: engine finishes the current character, then waits
  assign ctrl.cts_hold   = s_reg.efc[ulm_pkg::ENH_ACTS] & ~mstat[0];

endmodule

// file: verification/ulm_status_ctrl_sva.sv
// Assertion checker for the line/modem status slice
`timescale 1ns/1ps
module ulm_status_ctrl_sva (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Engine side
  input wire ulm_pkg::ulm_rx_evt_t rx_evt,
  input wire logic                 rx_break_frame,
  input wire logic                 rx_store,
  input wire logic                 rx_to_receiver,
  input wire logic                 tx_halted,
  input wire logic                 tx_serial,
  input wire logic [3:0]           tx_bit_phase,
  input wire logic                 tx_resume,
  input wire logic                 brg_clk_en,
  input wire ulm_pkg::ulm_ctrl_t   ctrl,
  // Pins
  input wire logic                 tx_pin,
  input wire ulm_pkg::ulm_modem_t  modem_pins,
  input wire logic                 dtr_n,
  input wire logic                 rts_n,
  input wire logic                 ri_loop_n,
  input wire logic                 aux_output_two_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic loop_on;
  logic loop_exp;
  logic ir_on;
  logic ir_exp;
  // Pin outputs are registered, so expectations lag one cycle
  always_ff @(posedge aclk)
  begin
    loop_on  <= aresetn && ctrl.loopback;
    loop_exp <= tx_serial;
    ir_on    <= aresetn && ctrl.ir_enable && !ctrl.loopback && !ctrl.tx_disable;
    ir_exp   <= !tx_serial && (tx_bit_phase < (ctrl.fast_ir ? ulm_pkg::IR_FAST_W : ulm_pkg::IR_SLOW_W));
  end
  property p_loop_route;
    loop_on && ctrl.loopback |-> rx_to_receiver == loop_exp;
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loop data not routed");
  property p_loop_pins;
    ctrl.loopback |-> dtr_n && rts_n;
  endproperty
  a_loop_pins: assert property (p_loop_pins) else $error("modem outputs active in loop");
  property p_ring_aux;
    !ctrl.loopback |-> ri_loop_n && aux_output_two_n;
  endproperty
  a_ring_aux: assert property (p_ring_aux) else $error("ring or aux low outside loop");
  property p_xany;
    rx_evt.done && ctrl.xon_any && tx_halted |=> tx_resume;
  endproperty
  a_xany: assert property (p_xany) else $error("no resume on character");
  property p_resume_cause;
    tx_resume |-> $past(rx_evt.done) && $past(ctrl.xon_any) && $past(tx_halted);
  endproperty
  a_resume_cause: assert property (p_resume_cause) else $error("resume without cause");
  property p_no_store;
    rx_evt.done && (rx_evt.flow_char || ctrl.rx_disable) && !rx_break_frame |=> !rx_store;
  endproperty
  a_no_store: assert property (p_no_store) else $error("flow or disabled char stored");
  property p_ir_tx;
    ir_on |-> tx_pin == ir_exp;
  endproperty
  a_ir_tx: assert property (p_ir_tx) else $error("infrared pulse wrong");
  property p_brg;
    $rose(brg_clk_en) |=> !brg_clk_en [*3] ##1 brg_clk_en;
  endproperty
  a_brg: assert property (p_brg) else $error("prescaled enable spacing wrong");
  property p_cts;
    (!ctrl.loopback && !modem_pins.cts_n) [*3] |-> !ctrl.cts_hold;
  endproperty
  a_cts: assert property (p_cts) else $error("transmitter held with clear to send");
endmodule

bind ulm_status_ctrl ulm_status_ctrl_sva ulm_status_ctrl_sva_i (.aclk, .aresetn, .rx_evt, .rx_break_frame,
  .rx_store, .rx_to_receiver, .tx_halted, .tx_serial, .tx_bit_phase, .tx_resume, .brg_clk_en, .ctrl,
  .tx_pin, .modem_pins, .dtr_n, .rts_n, .ri_loop_n, .aux_output_two_n);

// file: verification/ulm_line_model.sv
// Behavioural remote station driving the line and modem pins
`timescale 1ns/1ps
module ulm_line_model (
  // Clock
  input  wire logic           aclk,
  // Commands from the bench
  input  wire logic [3:0]     pins_cmd,
  input  wire logic           line_break,
  // Line and modem pins
  output ulm_pkg::ulm_modem_t modem_pins,
  output logic                rx_pin,
  output logic                ir_rx_pin
);
  initial
  begin
    modem_pins = 4'hf;
    rx_pin = 1'h1;
  end
  // High cts_n tells the device to stop after its current character
  always @(posedge aclk)
  begin
    modem_pins <= pins_cmd;
    rx_pin     <= !line_break;
  end
  // No infrared traffic from this station
  assign ir_rx_pin = 1'h0;
endmodule

// file: verification/ulm_status_ctrl_test.sv
// Self-checking bench for the line/modem status slice
`timescale 1ns/1ps
module ulm_status_ctrl_test;
  localparam int DEPTH = 4;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, tx_bit_phase = 4'h0, pins_cmd = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_break_frame = 1'h0, rx_pop = 1'h0;
  logic        tx_fifo_empty = 1'h1, tx_shift_empty = 1'h1, tx_halted = 1'h0, tx_serial = 1'h1;
  logic        baud16_en = 1'h0, line_break = 1'h0, rx_pin, ir_rx_pin;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rx_store, rx_to_receiver, tx_resume, brg_clk_en, tx_pin, dtr_n, rts_n;
  logic        ri_loop_n, aux_output_two_n, line_irq, mdm_irq;
  logic [17:0] e;
  ulm_pkg::ulm_rx_evt_t rx_evt = '0;
  ulm_pkg::ulm_ctrl_t   ctrl;
  ulm_pkg::ulm_modem_t  modem_pins;
  logic [17:0] rq[$];
  logic [1:0]  wq[$];
  int          failures = 0, total_checks = 0, seed = 99438;

  ulm_status_ctrl #(.DEPTH(DEPTH)) ulm_status_ctrl_i (.*);
  ulm_line_model ulm_line_model_i (.*);

  always #2 aclk = ~aclk;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Each answer meets the oldest driver note
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
    begin
      e = rq.pop_front();
      check("rdata", s_axi_rdata[7:0] & e[17:10], e[7:0] & e[17:10]);
      check("rresp", 8'(s_axi_rresp), 8'(e[9:8]));
    end
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
      check("bresp", 8'(s_axi_bresp), 8'(wq.pop_front()));
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
    logic aw, w;
    wq.push_back(r);
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1)
        aw = 1'h1;
      if (s_axi_wready === 1'h1)
        w = 1'h1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m = 8'hff,
                    input logic [1:0] r = 2'h0);
    rq.push_back({m, r, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic ev(input logic [3:0] v, input logic st, input logic rs);
    rx_evt <= v;
    @(posedge aclk);
    rx_evt <= '0;
    @(posedge aclk);
    check("rx_store", 8'(rx_store), 8'(st));
    check("tx_resume", 8'(tx_resume), 8'(rs));
  endtask

  task automatic brk(input logic st);
    line_break <= 1'h1;
    tick(2);
    rx_break_frame <= 1'h1;
    @(posedge aclk);
    rx_break_frame <= 1'h0;
    @(posedge aclk);
    check("break_store", 8'(rx_store), 8'(st));
  endtask

  task automatic pop(input int n);
    repeat (n)
    begin
      rx_pop <= 1'h1;
      @(posedge aclk);
      rx_pop <= 1'h0;
      @(posedge aclk);
    end
  endtask

  task automatic rnd(input int n);
    repeat (n)
    begin
      {baud16_en, tx_serial, tx_bit_phase} <= 6'($random(seed));
      @(posedge aclk);
    end
  endtask

  task automatic cnt(input int exp);
    int n;
    n = 0;
    repeat (16)
    begin
      @(posedge aclk);
      if (brg_clk_en === 1'h1)
        n++;
    end
    check("brg_count", 8'(n), 8'(exp));
  endtask

  task automatic rst;
    aresetn <= 1'h0;
    tick(16);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask

  initial
  begin
    rst();
    rd(8'h0c, 8'hff);
    rd(8'h04, 8'h60);
    wr(8'h04, 8'hff);
    tx_fifo_empty <= 1'h0;
    rd(8'h04, 8'h00);
    tx_fifo_empty <= 1'h1;
    tx_shift_empty <= 1'h0;
    rd(8'h04, 8'h20);
    tx_shift_empty <= 1'h1;
    wr(8'h18, 8'h5a, ulm_pkg::RESP_SLVERR);
    rd(8'h18, 8'h00, 8'hff, ulm_pkg::RESP_SLVERR);
    $display("test reset and map done");
    d = 8'($random(seed));
    wr(8'h0c, d);
    wr(8'h08, 8'hf0);
    rd(8'h0c, d);
    check("features", 8'(ctrl[7:4]), 8'h00);
    wr(8'h00, 8'he0);
    rd(8'h00, 8'h00);
    wr(8'h10, 8'h10);
    wr(8'h08, 8'hf0);
    check("features", 8'(ctrl[7:4]), 8'h0f);
    rd(8'h08, 8'h00);
    ev(4'h8, 1'h0, 1'h0);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h20);
    rd(8'h00, 8'h20);
    tx_halted <= 1'h1;
    ev(4'h9, 1'h0, 1'h1);
    ev(4'h8, 1'h1, 1'h1);
    tx_halted <= 1'h0;
    pop(1);
    wr(8'h00, 8'h00);
    $display("test feature enables done");
    wr(8'h14, 8'h04);
    ev(4'hc, 1'h1, 1'h0);
    rd(8'h04, 8'he5);
    check("line_irq", 8'(line_irq), 8'h01);
    ev(4'ha, 1'h1, 1'h0);
    ev(4'h8, 1'h1, 1'h0);
    pop(1);
    rd(8'h04, 8'he9);
    pop(1);
    rd(8'h04, 8'h61);
    check("line_irq", 8'(line_irq), 8'h00);
    pop(1);
    rd(8'h04, 8'h60);
    repeat (DEPTH) ev(4'h8, 1'h1, 1'h0);
    ev(4'h8, 1'h0, 1'h0);
    check("line_irq", 8'(line_irq), 8'h01);
    rd(8'h04, 8'h63);
    rd(8'h04, 8'h61);
    check("line_irq", 8'(line_irq), 8'h00);
    pop(DEPTH);
    rd(8'h04, 8'h60);
    $display("test receive status done");
    brk(1'h1);
    brk(1'h0);
    rd(8'h04, 8'hf1, 8'hf7);
    pop(1);
    line_break <= 1'h0;
    tick(4);
    brk(1'h1);
    pop(1);
    line_break <= 1'h0;
    tick(2);
    rd(8'h04, 8'h60);
    $display("test break done");
    wr(8'h14, 8'h08);
    rd(8'h08, 8'h00);
    pins_cmd <= 4'h0;
    tick(4);
    check("mdm_irq", 8'(mdm_irq), 8'h01);
    rd(8'h08, 8'hfb);
    rd(8'h08, 8'hf0);
    pins_cmd <= 4'h2;
    tick(4);
    rd(8'h08, 8'hb4);
    pins_cmd <= 4'hf;
    tick(4);
    rd(8'h08, 8'h0b);
    check("mdm_irq", 8'(mdm_irq), 8'h00);
    $display("test modem status done");
    wr(8'h00, 8'h1f);
    rd(8'h08, 8'hf0, 8'hf0);
    check("loop_pins", 8'({dtr_n, rts_n, ri_loop_n, aux_output_two_n}), 8'h0c);
    rnd(20);
    wr(8'h00, 8'h10);
    rd(8'h08, 8'h00, 8'hf0);
    check("loop_pins", 8'({ri_loop_n, aux_output_two_n}), 8'h03);
    wr(8'h00, 8'h40);
    rnd(40);
    wr(8'h08, 8'h80);
    rnd(40);
    tx_serial <= 1'h1;
    tick(3);
    check("ir_idle", 8'(tx_pin), 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    $display("test loopback and infrared done");
    wr(8'h10, 8'h90);
    tick(4);
    check("cts_hold", 8'(ctrl.cts_hold), 8'h01);
    pins_cmd <= 4'h7;
    tick(4);
    check("cts_hold", 8'(ctrl.cts_hold), 8'h00);
    pins_cmd <= 4'hf;
    wr(8'h10, 8'h10);
    cnt(16);
    wr(8'h00, 8'h80);
    tick(4);
    cnt(4);
    rst();
    rd(8'h0c, 8'hff);
    $display("test flow control and prescaler done");
    stop_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    failures++;
    stop_test();
  end
endmodule
